// file: tb_ulms_channel.sv
// self-checking bench for the uart control and status channel
`timescale 1ns/10ps
`default_nettype none
module tb_ulms_channel;
  import ulms_pkg::*;
  // short bit time keeps the run brief
  localparam int BC = 4;
  logic        clock   = 1'b0;
  logic        sys_rst = 1'b1;
  logic        cs      = 1'b0;
  logic [2:0]  addr    = 3'h0;
  logic        rd_stb  = 1'b0;
  logic        wr_stb  = 1'b0;
  logic [7:0]  wdata   = 8'h00;
  logic [7:0]  rdata;
  logic        rx, cts_n, dsr_n, ri_n, cd_n;
  logic        tx, rts_n, dtr_n, irq_out, irq_oe;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          nb;
  logic [7:0]  v;
  logic [15:0] f, g;
  logic [3:0]  ln = 4'hf;
  logic [7:0]  rq[$];
  logic [7:0]  fmt[10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h08,
                           8'h19, 8'h2a, 8'h3b, 8'h04, 8'h0f};
  logic [15:0] flp[4] = '{16'h0, 16'h0200, 16'h0400, 16'h0};
  logic [7:0]  er[4]  = '{8'h00, 8'h04, 8'h08, 8'h18};
  logic [7:0]  ids[5] = '{{4'h0, ID_LS}, {4'h0, ID_RX}, {4'h0, ID_TX},
                          {4'h0, ID_MS}, RST_IDENT};

  always #20 clock = ~clock;

  ulms_channel #(.BIT_CLKS(BC), .RX_DEPTH(2)) ulms_channel_inst (
    .clock(clock), .sys_rst(sys_rst), .cs(cs), .addr(addr),
    .rd_stb(rd_stb), .wr_stb(wr_stb), .wdata(wdata), .rdata(rdata),
    .rx(rx), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .cd_n(cd_n),
    .tx(tx), .rts_n(rts_n), .dtr_n(dtr_n), .irq_out(irq_out),
    .irq_oe(irq_oe));
  ulms_peer #(.BIT_CLKS(BC)) ulms_peer_inst (
    .clock(clock), .tx(tx), .rx(rx), .cts_n(cts_n), .dsr_n(dsr_n),
    .ri_n(ri_n), .cd_n(cd_n));

  // --------------------------------
  // bus tasks and reference model
  // --------------------------------
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clock);
    {cs, wr_stb, addr, wdata} = {2'b11, a, d};
    @(negedge clock);
    {cs, wr_stb} = 2'b00;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge clock);
    {cs, rd_stb, addr} = {2'b11, a};
    @(negedge clock);
    {cs, rd_stb} = 2'b00;
    d = rdata;
  endtask

  task automatic chk(input logic [15:0] gv, input logic [15:0] e,
                     input string w);
    cmp_count++;
    if (gv !== e) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, w, gv, e);
    end
  endtask

  task automatic rc(input logic [2:0] a, input logic [7:0] m,
                    input logic [7:0] e, input string w);
    logic [7:0] d;
    rd(a, d);
    chk({8'h00, d & m}, {8'h00, e}, w);
  endtask

  // whole frame: start, data lsb first, optional parity, one stop
  function automatic logic [15:0] frame(input logic [7:0] d,
                                        input logic [7:0] l, output int n);
    logic [7:0] m;
    n = 5 + int'(l[1:0]);
    m = d & 8'((1 << n) - 1);
    frame = {7'h0, m, 1'b0};
    n = n + 1;
    if (l[LCR_PAREN]) begin
      frame[n] = l[LCR_FORCE] ? ~l[LCR_EVEN] : ^m ^ ~l[LCR_EVEN];
      n++;
    end
    frame[n] = 1'b1;
    n++;
  endfunction

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // --------------------------------
  // tests
  // --------------------------------
  initial begin
    void'($urandom(84572));
    repeat (20) @(negedge clock);
    sys_rst = 1'b0;
    chk({12'h0, tx, rts_n, dtr_n, irq_oe}, 16'h000e, "pins");
    rc(ADDR_IDENT, 8'hff, RST_IDENT, "ident");
    rc(ADDR_LSR, 8'hff, RST_LSR, "lsr");
    rc(ADDR_LCR, 8'hff, RST_ZERO, "lcr");
    rc(ADDR_MCR, 8'hff, RST_ZERO, "mcr");
    rc(ADDR_MSR, 8'hff, RST_ZERO, "msr");
    $display("test reset done");
    v = 8'($urandom);
    wr(ADDR_SCR, v);
    rc(ADDR_SCR, 8'hff, v, "scratch");
    wr(ADDR_LSR, 8'h1f);
    rc(ADDR_LSR, 8'hff, RST_LSR, "lsr ro");
    wr(ADDR_LCR, 8'hff);
    repeat (2) @(negedge clock);
    chk({15'h0, tx}, 16'h0, "break");
    rc(ADDR_LCR, 8'hff, 8'h7f, "lcr rw");
    wr(ADDR_LCR, 8'h03);
    repeat (2) @(negedge clock);
    chk({15'h0, tx}, 16'h1, "break off");
    for (int m = 0; m < 16; m++) begin
      wr(ADDR_MCR, 8'(m) | 8'he0);
      @(negedge clock);
      v = {5'h0, ~m[0], ~m[1], m[3]};
      chk({13'h0, dtr_n, rts_n, irq_oe}, {8'h00, v}, "pins");
      rc(ADDR_MCR, 8'hff, 8'(m), "mcr rw");
    end
    $display("test registers done");
    // lsr is read mid-frame while the peer catches the frame
    foreach (fmt[i]) begin
      wr(ADDR_LCR, fmt[i]);
      v = 8'($urandom);
      f = frame(v, fmt[i], nb);
      wr(ADDR_HOLD, v);
      fork
        ulms_peer_inst.recv(g, nb);
        begin
          repeat (8) @(negedge clock);
          rc(ADDR_LSR, 8'hff, 8'h20, "lsr busy");
        end
      join
      chk(g, f, "tx frame");
      repeat (3 * BC) @(negedge clock);
      rc(ADDR_LSR, 8'hff, RST_LSR, "lsr idle");
    end
    $display("test transmit done");
    wr(ADDR_LCR, 8'h1b);
    for (int k = 0; k < 4; k++) begin
      v = (k == 3) ? 8'h00 : 8'($urandom);
      f = frame(v, 8'h1b, nb);
      ulms_peer_inst.send((k == 3) ? 16'h0 : f ^ flp[k], nb);
      rc(ADDR_LSR, 8'h1f, 8'h01 | er[k], "rx st");
      rc(ADDR_HOLD, 8'hff, v, "rx data");
      rc(ADDR_LSR, 8'h1f, 8'h00, "rx clear");
    end
    for (int k = 0; k < 3; k++) begin
      rq.push_back(8'($urandom));
      f = frame(rq[k], 8'h1b, nb);
      ulms_peer_inst.send(f, nb);
    end
    rc(ADDR_LSR, 8'h03, 8'h03, "overrun");
    rc(ADDR_HOLD, 8'hff, rq[0], "held");
    rc(ADDR_HOLD, 8'hff, rq[1], "second");
    rc(ADDR_LSR, 8'h03, 8'h00, "drained");
    $display("test receive done");
    for (int j = 0; j < 4; j++) begin
      for (int s = 0; s < 2; s++) begin
        ln[j] = s[0];
        ulms_peer_inst.lines(ln);
        repeat (4) @(negedge clock);
        v = {~ln, (j == 2 && s == 0) ? 4'h0 : 4'(1 << j)};
        rc(ADDR_MSR, 8'hff, v, "msr");
        rc(ADDR_MSR, 8'h0f, 8'h00, "msr read");
      end
    end
    v = 8'($urandom) & 8'h0f;
    wr(ADDR_MCR, 8'h10 | v);
    repeat (4) @(negedge clock);
    rc(ADDR_MSR, 8'hf0, {v[3], v[2], v[0], v[1], 4'h0}, "loop ms");
    // five bits, forced parity one, long stop; bit four of v is always zero
    wr(ADDR_LCR, 8'h2c);
    wr(ADDR_HOLD, v);
    repeat (6 * BC) @(negedge clock);
    chk({15'h0, tx}, 16'h1, "loop tx");
    repeat (10 * BC) @(negedge clock);
    rc(ADDR_LSR, 8'hff, RST_LSR | 8'h01, "loop lsr");
    rc(ADDR_HOLD, 8'hff, v, "loop data");
    wr(ADDR_LCR, 8'h1b);
    wr(ADDR_MCR, 8'h08);
    $display("test modem done");
    // flush with the mask on so no latent source survives
    wr(ADDR_MASK, 8'hff);
    rc(ADDR_MASK, 8'hff, 8'h0f, "mask");
    rd(ADDR_LSR, v);
    rd(ADDR_MSR, v);
    repeat (4) rd(ADDR_IDENT, v);
    chk({15'h0, irq_out}, 16'h0, "irq idle");
    v = 8'($urandom);
    f = frame(v, 8'h1b, nb);
    wr(ADDR_HOLD, v);
    ulms_peer_inst.recv(g, nb);
    ln[0] = ~ln[0];
    ulms_peer_inst.lines(ln);
    ulms_peer_inst.send(f ^ 16'h0200, nb);
    chk({15'h0, irq_out}, 16'h1, "irq set");
    foreach (ids[i]) rc(ADDR_IDENT, 8'hff, ids[i], "ident");
    chk({15'h0, irq_out}, 16'h0, "irq done");
    $display("test interrupt done");
    give_verdict;
  end

  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    give_verdict;
  end
endmodule
`default_nettype wire

// file: ulms_channel.sv
// one uart channel: registers, framing, status and interrupt identification
`timescale 1ns/10ps
`default_nettype none
module ulms_channel #(
  parameter int BIT_CLKS = 16,
  parameter int RX_DEPTH = 2
) (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       cs,
  input  wire logic [2:0] addr,
  input  wire logic       rd_stb,
  input  wire logic       wr_stb,
  input  wire logic [7:0] wdata,
  output var  logic [7:0] rdata,
  input  wire logic       rx,
  input  wire logic       cts_n,
  input  wire logic       dsr_n,
  input  wire logic       ri_n,
  input  wire logic       cd_n,
  output var  logic       tx,
  output var  logic       rts_n,
  output var  logic       dtr_n,
  output var  logic       irq_out,
  output var  logic       irq_oe
);
  import ulms_pkg::*;
  localparam int HALF = BIT_CLKS / 2;
  localparam int CW   = $clog2(2 * BIT_CLKS + 1) + 1;
  localparam int PW   = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;
  localparam logic [CW-1:0] BIT_LD  = CW'(BIT_CLKS - 1);
  localparam logic [CW-1:0] HALF_LD = CW'(HALF - 1);

  // ----------------------------------------------------------------
  // bus decode and control registers
  // ----------------------------------------------------------------
  logic       rd_hit, wr_hit;
  logic [7:0] lcr_reg, mcr_reg, mask_reg, scr_reg;
  assign rd_hit = cs & rd_stb;
  assign wr_hit = cs & wr_stb;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lcr_reg  <= RST_ZERO;
      mcr_reg  <= RST_ZERO;
      mask_reg <= RST_ZERO;
    end else if (wr_hit) begin
      case (addr)
        ADDR_LCR:  lcr_reg  <= {1'b0, wdata[6:0]};
        ADDR_MCR:  mcr_reg  <= {3'h0, wdata[4:0]};
        ADDR_MASK: mask_reg <= {4'h0, wdata[3:0]};
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst)
      scr_reg <= RST_ZERO;
    else if (wr_hit && addr == ADDR_SCR)
      scr_reg <= wdata;
  end

  logic       loop;
  logic [3:0] nbits;
  logic [2:0] stop_h;
  assign loop   = mcr_reg[MCR_LOOP];
  assign nbits  = 4'(5 + lcr_reg[1:0]);
  assign stop_h = !lcr_reg[LCR_STOP] ? STOP_ONE :
                  (lcr_reg[1:0] == LEN_5BIT) ? STOP_ONEH : STOP_TWO;

  function automatic logic par_bit(input logic [7:0] d, input logic [3:0] n,
                                   input logic [7:0] l);
    logic [7:0] m;
    m = d & 8'((9'h1 << n) - 9'h1);
    if (l[LCR_FORCE])
      par_bit = ~l[LCR_EVEN];
    else
      par_bit = l[LCR_EVEN] ? ^m : ~^m;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] pin_s1, pin_s2;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pin_s1 <= 5'h1f;
      pin_s2 <= 5'h1f;
    end else begin
      pin_s1 <= {rx, cd_n, ri_n, dsr_n, cts_n};
      pin_s2 <= pin_s1;
    end
  end

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  ulms_ser_t     tx_st;
  logic [CW-1:0] tx_cnt;
  logic [7:0]    thr_reg, tsr_reg;
  logic          thr_full, tx_par, tx_bit;
  logic [3:0]    tx_idx;

  always_ff @(posedge clock) begin
    if (sys_rst)
      thr_full <= 1'b0;
    else if (wr_hit && addr == ADDR_HOLD)
      thr_full <= 1'b1;
    else if (tx_st == SER_IDLE)
      thr_full <= 1'b0;
  end

  always_ff @(posedge clock) begin
    if (wr_hit && addr == ADDR_HOLD)
      thr_reg <= wdata;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tx_st  <= SER_IDLE;
      tx_cnt <= '0;
      tx_idx <= 4'h0;
    end else if (tx_st == SER_IDLE) begin
      if (thr_full) begin
        tsr_reg <= thr_reg;
        tx_par  <= par_bit(thr_reg, nbits, lcr_reg);
        tx_st   <= SER_START;
        tx_cnt  <= BIT_LD;
      end
    end else if (tx_cnt != '0) begin
      tx_cnt <= tx_cnt - CW'(1);
    end else begin
      tx_cnt <= BIT_LD;
      case (tx_st)
        SER_START: begin
          tx_st  <= SER_DATA;
          tx_idx <= 4'h0;
        end
        SER_DATA: begin
          tsr_reg <= tsr_reg >> 1;
          tx_idx  <= tx_idx + 4'h1;
          if (tx_idx == nbits - 4'h1) begin
            if (lcr_reg[LCR_PAREN])
              tx_st <= SER_PAR;
            else begin
              tx_st  <= SER_STOP;
              tx_cnt <= CW'(stop_h * HALF - 1);
            end
          end
        end
        SER_PAR: begin
          tx_st  <= SER_STOP;
          tx_cnt <= CW'(stop_h * HALF - 1);
        end
        default: tx_st <= SER_IDLE;
      endcase
    end
  end

  always_comb begin
    case (tx_st)
      SER_START: tx_bit = 1'b0;
      SER_DATA:  tx_bit = tsr_reg[0];
      SER_PAR:   tx_bit = tx_par;
      default:   tx_bit = 1'b1;
    endcase
  end

  // pins come from flip-flops; loop-back parks tx at mark unless break holds it at space
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tx     <= 1'b1;
      rts_n  <= 1'b1;
      dtr_n  <= 1'b1;
      irq_oe <= 1'b0;
    end else begin
      tx     <= lcr_reg[LCR_BREAK] ? 1'b0 : (loop | tx_bit);
      rts_n  <= ~mcr_reg[MCR_RTS];
      dtr_n  <= ~mcr_reg[MCR_DTR];
      irq_oe <= mcr_reg[MCR_OUT2];
    end
  end

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  ulms_ser_t     rx_st;
  logic [CW-1:0] rx_cnt;
  logic [7:0]    rsr_reg;
  logic [3:0]    rx_idx;
  logic          rx_in, rx_pe, rx_zero, rx_done;
  logic [10:0]   rx_word;
  assign rx_in = loop ? tx_bit : pin_s2[4];

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rx_st   <= SER_IDLE;
      rx_cnt  <= '0;
      rx_idx  <= 4'h0;
      rx_done <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (rx_st == SER_IDLE) begin
        if (!rx_in) begin
          rx_st  <= SER_START;
          rx_cnt <= HALF_LD;
        end
      end else if (rx_cnt != '0) begin
        rx_cnt <= rx_cnt - CW'(1);
      end else begin
        rx_cnt <= BIT_LD;
        case (rx_st)
          // a glitch shorter than half a bit is dropped here
          SER_START: begin
            rx_st   <= rx_in ? SER_IDLE : SER_DATA;
            rx_idx  <= 4'h0;
            rx_zero <= 1'b1;
            rsr_reg <= 8'h00;
          end
          SER_DATA: begin
            rsr_reg[rx_idx[2:0]] <= rx_in;
            rx_zero <= rx_zero & ~rx_in;
            rx_idx  <= rx_idx + 4'h1;
            if (rx_idx == nbits - 4'h1)
              rx_st <= lcr_reg[LCR_PAREN] ? SER_PAR : SER_STOP;
          end
          SER_PAR: begin
            rx_pe   <= rx_in != par_bit(rsr_reg, nbits, lcr_reg);
            rx_zero <= rx_zero & ~rx_in;
            rx_st   <= SER_STOP;
          end
          default: begin
            if (!lcr_reg[LCR_PAREN])
              rx_pe <= 1'b0;
            rx_word <= {rx_zero & ~rx_in, ~rx_in, 1'b0, rsr_reg};
            rx_done <= 1'b1;
            rx_st   <= SER_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // receive buffer, its head is the receive holding register
  // ----------------------------------------------------------------
  logic [10:0]   rxq [RX_DEPTH];
  logic [PW-1:0] wptr, rptr;
  logic [PW:0]   rx_count;
  logic          rx_push, rx_pop, rx_full, rx_ready;
  assign rx_ready = rx_count != (PW+1)'(RX_DEPTH);
  assign rx_full  = !rx_ready;
  assign rx_push  = rx_done & rx_ready;
  assign rx_pop   = rd_hit && addr == ADDR_HOLD && rx_count != '0;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wptr     <= '0;
      rptr     <= '0;
      rx_count <= '0;
    end else begin
      if (rx_push) begin
        rxq[wptr] <= {rx_word[10:9], rx_pe, rx_word[7:0]};
        wptr <= (wptr == PW'(RX_DEPTH - 1)) ? '0 : wptr + PW'(1);
      end
      if (rx_pop)
        rptr <= (rptr == PW'(RX_DEPTH - 1)) ? '0 : rptr + PW'(1);
      rx_count <= rx_count + (PW+1)'(rx_push) - (PW+1)'(rx_pop);
    end
  end

  // ----------------------------------------------------------------
  // line status and modem status
  // ----------------------------------------------------------------
  logic [3:0] err_reg, msd_reg, ms_now, ms_prev, ms_evt;
  logic       rd_lsr, rd_msr, err_evt;
  logic [7:0] lsr_val, msr_val;
  assign rd_lsr  = rd_hit && addr == ADDR_LSR;
  assign rd_msr  = rd_hit && addr == ADDR_MSR;
  assign err_evt = rx_done & (rx_full | rx_pe | rx_word[9] | rx_word[10]);

  // error flags: set wins over the clearing read
  always_ff @(posedge clock) begin
    if (sys_rst)
      err_reg <= 4'h0;
    else
      err_reg <= (rd_lsr ? 4'h0 : err_reg) | ({4{rx_done}} &
                 {rx_word[10], rx_word[9], rx_pe, rx_full});
  end

  // {cd, ri, dsr, cts} active high
  assign ms_now = loop ? {mcr_reg[MCR_OUT2], mcr_reg[MCR_OUT1],
                          mcr_reg[MCR_DTR], mcr_reg[MCR_RTS]}
                       : ~pin_s2[3:0];
  assign ms_evt = {ms_now[3] ^ ms_prev[3], ms_prev[2] & ~ms_now[2],
                   ms_now[1:0] ^ ms_prev[1:0]};

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ms_prev <= 4'h0;
      msd_reg <= 4'h0;
    end else begin
      ms_prev <= ms_now;
      msd_reg <= (rd_msr ? 4'h0 : msd_reg) | ms_evt;
    end
  end

  assign lsr_val = {1'b0, ~thr_full & (tx_st == SER_IDLE), ~thr_full,
                    err_reg, rx_count != '0};
  assign msr_val = {ms_now, msd_reg};

  // ----------------------------------------------------------------
  // interrupt identification
  // ----------------------------------------------------------------
  logic [3:0] pend_reg, pend_set, pend_clr, act;
  logic [3:0] id_code;
  logic       thre_prev, rd_id;
  assign rd_id = rd_hit && addr == ADDR_IDENT;
  assign act   = pend_reg & mask_reg[3:0];

  always_comb begin
    if (act[IM_LS])      id_code = ID_LS;
    else if (act[IM_RX]) id_code = ID_RX;
    else if (act[IM_TX]) id_code = ID_TX;
    else if (act[IM_MS]) id_code = ID_MS;
    else                 id_code = ID_NONE;
  end

  always_comb begin
    pend_set        = 4'h0;
    pend_set[IM_RX] = rx_push;
    pend_set[IM_TX] = ~thr_full & ~thre_prev;
    pend_set[IM_LS] = err_evt;
    pend_set[IM_MS] = |ms_evt;
    pend_clr        = 4'h0;
    pend_clr[IM_RX] = rx_pop && rx_count == (PW+1)'(1);
    pend_clr[IM_TX] = wr_hit && addr == ADDR_HOLD;
    pend_clr[IM_LS] = rd_lsr;
    pend_clr[IM_MS] = rd_msr;
    if (rd_id) begin
      case (id_code)
        ID_LS:   pend_clr[IM_LS] = 1'b1;
        ID_RX:   pend_clr[IM_RX] = 1'b1;
        ID_TX:   pend_clr[IM_TX] = 1'b1;
        ID_MS:   pend_clr[IM_MS] = 1'b1;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pend_reg  <= 4'h0;
      thre_prev <= 1'b1;
      irq_out   <= 1'b0;
    end else begin
      pend_reg  <= (pend_reg & ~pend_clr) | pend_set;
      thre_prev <= ~thr_full;
      irq_out   <= |act;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst)
      rdata <= RST_ZERO;
    else if (rd_hit) begin
      case (addr)
        ADDR_HOLD:  rdata <= rxq[rptr][7:0];
        ADDR_MASK:  rdata <= mask_reg;
        ADDR_IDENT: rdata <= {4'h0, id_code};
        ADDR_LCR:   rdata <= lcr_reg;
        ADDR_MCR:   rdata <= mcr_reg;
        ADDR_LSR:   rdata <= lsr_val;
        ADDR_MSR:   rdata <= msr_val;
        default:    rdata <= scr_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_id_prio;
    @(posedge clock) disable iff (sys_rst)
      rd_id && act[IM_LS] |=> rdata == {4'h0, ID_LS};
  endproperty
  a_id_prio: assert property (p_id_prio) else $error("priority");
  property p_id_read;
    @(posedge clock) disable iff (sys_rst)
      rd_id |=> rdata[7:4] == 4'h0 && rdata[0] == ~|$past(act);
  endproperty
  a_id_read: assert property (p_id_read) else $error("ident bits");
  property p_id_clr;
    @(posedge clock) disable iff (sys_rst)
      rd_id && act[IM_LS] && !pend_set[IM_LS] |=> !pend_reg[IM_LS] &&
        ($past(pend_reg) & ~pend_reg & ~(4'h1 << IM_LS)) == 4'h0;
  endproperty
  a_id_clr: assert property (p_id_clr) else $error("ident clear");
  property p_break;
    @(posedge clock) disable iff (sys_rst)
      lcr_reg[LCR_BREAK] [*2] |-> !tx;
  endproperty
  a_break: assert property (p_break) else $error("break");
  property p_pins;
    @(posedge clock) disable iff (sys_rst)
      ##1 dtr_n == !$past(mcr_reg[MCR_DTR]) &&
          rts_n == !$past(mcr_reg[MCR_RTS]);
  endproperty
  a_pins: assert property (p_pins) else $error("dtr rts");
  property p_ri_edge;
    @(posedge clock) disable iff (sys_rst)
      $fell(ms_now[2]) && !rd_msr |=> msd_reg[2];
  endproperty
  a_ri_edge: assert property (p_ri_edge) else $error("ri delta");
  property p_overrun;
    @(posedge clock) disable iff (sys_rst)
      rx_done && rx_full && !rx_pop |=> err_reg[0] && rx_full &&
                                       $stable(wptr);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun");
  property p_stop;
    @(posedge clock) disable iff (sys_rst)
      $rose(tx_st == SER_STOP) |-> tx_cnt == CW'(stop_h * HALF - 1);
  endproperty
  a_stop: assert property (p_stop) else $error("stop length");
  property p_temt;
    @(posedge clock) disable iff (sys_rst)
      rd_lsr && (thr_full || tx_st != SER_IDLE) |=> !rdata[LSR_TEMT];
  endproperty
  a_temt: assert property (p_temt) else $error("temt");
  c_rx:   cover property (@(posedge clock) rx_push);
  c_ovr:  cover property (@(posedge clock) rx_done && rx_full);
  c_loop: cover property (@(posedge clock) loop && |msd_reg);
endmodule
`default_nettype wire

// file: ulms_peer.sv
// modem side peer: serial frames on the line and the modem input pins
`timescale 1ns/10ps
`default_nettype none
module ulms_peer #(
  parameter int BIT_CLKS = 4
) (
  input  wire logic clock,
  input  wire logic tx,
  output var  logic rx,
  output var  logic cts_n,
  output var  logic dsr_n,
  output var  logic ri_n,
  output var  logic cd_n
);
  // line idles at mark, modem pins start inactive
  initial begin
    rx = 1'b1;
    {cd_n, ri_n, dsr_n, cts_n} = 4'hf;
  end

  // drives all four modem pins, bit 0 is the clear-to-send pin
  task automatic lines(input logic [3:0] s);
    {cd_n, ri_n, dsr_n, cts_n} = s;
  endtask

  // nb bits lsb first, one bit time each, then one bit time of mark
  task automatic send(input logic [15:0] f, input int nb);
    for (int i = 0; i < nb; i++) begin
      rx = f[i];
      repeat (BIT_CLKS) @(negedge clock);
    end
    rx = 1'b1;
    repeat (BIT_CLKS) @(negedge clock);
  endtask

  // samples at bit centres; a missing start leaves a garbage frame
  task automatic recv(output logic [15:0] f, input int nb);
    int n;
    f = 16'h0000;
    n = 0;
    while (tx !== 1'b0 && n < 4000) begin
      @(negedge clock);
      n++;
    end
    repeat (BIT_CLKS / 2) @(negedge clock);
    for (int i = 0; i < nb; i++) begin
      f[i] = tx;
      repeat (BIT_CLKS) @(negedge clock);
    end
  endtask
endmodule
`default_nettype wire

// file: ulms_pkg.sv
// constants shared by the uart control and status channel
package ulms_pkg;
  // register addresses on the three-bit bus
  localparam logic [2:0] ADDR_HOLD  = 3'h0;
  localparam logic [2:0] ADDR_MASK  = 3'h1;
  localparam logic [2:0] ADDR_IDENT = 3'h2;
  localparam logic [2:0] ADDR_LCR   = 3'h3;
  localparam logic [2:0] ADDR_MCR   = 3'h4;
  localparam logic [2:0] ADDR_LSR   = 3'h5;
  localparam logic [2:0] ADDR_MSR   = 3'h6;
  localparam logic [2:0] ADDR_SCR   = 3'h7;
  // line format control fields
  localparam int LCR_STOP   = 2;
  localparam int LCR_PAREN  = 3;
  localparam int LCR_EVEN   = 4;
  localparam int LCR_FORCE  = 5;
  localparam int LCR_BREAK  = 6;
  // modem output control fields
  localparam int MCR_DTR    = 0;
  localparam int MCR_RTS    = 1;
  localparam int MCR_OUT1   = 2;
  localparam int MCR_OUT2   = 3;
  localparam int MCR_LOOP   = 4;
  // line status fields
  localparam int LSR_DR     = 0;
  localparam int LSR_OE     = 1;
  localparam int LSR_PE     = 2;
  localparam int LSR_FE     = 3;
  localparam int LSR_BI     = 4;
  localparam int LSR_THRE   = 5;
  localparam int LSR_TEMT   = 6;
  // interrupt mask fields
  localparam int IM_RX      = 0;
  localparam int IM_TX      = 1;
  localparam int IM_LS      = 2;
  localparam int IM_MS      = 3;
  // identification codes and reset values
  localparam logic [3:0] ID_LS   = 4'h6;
  localparam logic [3:0] ID_RX   = 4'h4;
  localparam logic [3:0] ID_TX   = 4'h2;
  localparam logic [3:0] ID_MS   = 4'h0;
  localparam logic [3:0] ID_NONE = 4'h1;
  localparam logic [7:0] RST_IDENT = 8'h01;
  localparam logic [7:0] RST_LSR   = 8'h60;
  localparam logic [7:0] RST_ZERO  = 8'h00;
  localparam logic [1:0] LEN_5BIT  = 2'h0;
  // stop length in half bit times
  localparam logic [2:0] STOP_ONE   = 3'h2;
  localparam logic [2:0] STOP_ONEH  = 3'h3;
  localparam logic [2:0] STOP_TWO   = 3'h4;
  typedef enum logic [2:0] {
    SER_IDLE, SER_START, SER_DATA, SER_PAR, SER_STOP
  } ulms_ser_t;
endpackage
